/* rtl/acd_pkg.sv */
// Package: command layout, reset values, delays and configuration carriers
package acd_pkg;
    // Command byte prefixes
    localparam int CMD_CONV_BIT = 7;
    localparam int CMD_SETUP_BIT = 6;
    // Conversion byte fields
    localparam int CONV_CH_MSB = 6;
    localparam int CONV_CH_LSB = 3;
    localparam int CONV_SCAN_MSB = 2;
    localparam int CONV_SCAN_LSB = 1;
    localparam int CONV_TEMP_BIT = 0;
    // Setup byte fields
    localparam int SET_CLK_MSB = 5;
    localparam int SET_CLK_LSB = 4;
    localparam int SET_REF_MSB = 3;
    localparam int SET_REF_LSB = 2;
    localparam int SET_POL_MSB = 1;
    localparam int SET_POL_LSB = 0;
    // Field encodings
    localparam logic [1:0] SCAN_UP_TO_N = 2'h0;
    localparam logic [1:0] SCAN_N_TO_TOP = 2'h1;
    localparam logic [1:0] SCAN_REPEAT = 2'h2;
    localparam logic [1:0] SCAN_SINGLE = 2'h3;
    localparam logic [1:0] CLK_INT_PIN_ACQ_INT = 2'h0;
    localparam logic [1:0] CLK_INT_PIN_ACQ_PIN = 2'h1;
    localparam logic [1:0] CLK_INT_NO_PIN = 2'h2;
    localparam logic [1:0] CLK_SERIAL = 2'h3;
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    // Reset values: upper clock-mode bit comes up set
    localparam logic [1:0] CLK_MODE_RESET = 2'h2;
    localparam logic [1:0] REF_MODE_RESET = 2'h0;
    localparam logic [1:0] POL_SEL_RESET = 2'h0;
    // Delays in conversion clock cycles
    localparam logic [7:0] DLY_TEMP_FORCED = 8'hbc;   // 188
    localparam logic [7:0] DLY_REF_WAKE = 8'hda;      // 218
    localparam logic [7:0] DLY_TEMP_SETTLE = 8'hf4;   // 244
    // Highest serial conversion clock in clock mode 11, in kHz
    localparam int SERIAL_CONV_CLK_MAX_KHZ = 3600;
    // Serial byte length
    localparam int BYTE_BITS = 8;

    typedef struct packed {
        logic [3:0] channel;
        logic [1:0] scan_mode;
        logic temp_req;
    } acd_conv_cfg_type;

    typedef struct packed {
        logic [1:0] clock_mode;
        logic [1:0] reference_mode;
        logic [1:0] polarity_select;
    } acd_setup_cfg_type;

    typedef struct packed {
        logic first_in_frame;
        logic [7:0] data;
    } acd_serial_byte_type;
endpackage

/* rtl/acd_command_decode.sv */
// Command decoder, setup/conversion configuration and scan sequencer
`timescale 1ns/10ps
module acd_command_decode #(
    parameter int NUM_CH = 12,
    parameter int INT_CLK_DIV = 4,
    parameter int REPEAT_UNIT = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk_link,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic convert_start_pin,
    input wire logic force_reference_on,
    input wire logic dac_any_powered,
    input wire logic dac_any_parked,
    input wire logic [1:0] repeat_count,
    input wire logic conv_done,
    output acd_pkg::acd_conv_cfg_type conv_cfg,
    output acd_pkg::acd_setup_cfg_type setup_cfg,
    output logic pol_sel_wr,
    output logic [7:0] other_cmd,
    output logic other_cmd_first,
    output logic other_cmd_valid,
    output logic start_pin_is_input,
    output logic second_ref_is_input,
    output logic acq_by_start_pin,
    output logic conv_by_sclk,
    output logic ref_on,
    output logic conv_req,
    output logic [3:0] conv_channel,
    output logic conv_temp,
    output logic scan_busy
);
    import acd_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_TEMP_WAIT, ST_TEMP_CONV, ST_REF_WAIT, ST_CH_SEL, ST_CH_CONV
    } acd_state_type;

    // ---- Link domain: byte assembly on the serial clock ----
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic first_reg;
    acd_serial_byte_type hold_reg;
    logic tog_reg;
    wire byte_end = (bit_cnt_reg == 3'(BYTE_BITS - 1));

    // Shift serial data; chip select high restarts the frame
    always_ff @(posedge sclk_link or negedge rst_n or posedge cs_n) begin
        if (!rst_n || cs_n) begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            first_reg <= 1'b1;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= {shift_reg[5:0], sdi};
            if (byte_end) begin
                first_reg <= 1'b0;
            end
        end
    end

    // Publish a whole byte and flag it by a toggle
    always_ff @(posedge sclk_link or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= '0;
            tog_reg <= 1'b0;
        end else if (!cs_n && byte_end) begin
            hold_reg <= {first_reg, shift_reg, sdi};
            tog_reg <= ~tog_reg;
        end
    end

    // ---- Crossings into the system domain ----
    logic tog_s1_reg, tog_s2_reg, tog_seen_reg;
    logic sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
    logic pin_s1_reg, pin_s2_reg, pin_d_reg;

    // Two-flop synchronisers and edge history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_seen_reg <= 1'b0;
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_d_reg <= 1'b0;
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            pin_d_reg <= 1'b1;
        end else begin
            tog_s1_reg <= tog_reg;
            tog_s2_reg <= tog_s1_reg;
            tog_seen_reg <= tog_s2_reg;
            sclk_s1_reg <= sclk_link;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_d_reg <= sclk_s2_reg;
            pin_s1_reg <= convert_start_pin;
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg <= pin_s2_reg;
        end
    end

    // ---- Command decode ----
    wire byte_arrived = tog_s2_reg ^ tog_seen_reg;
    wire [7:0] rx = hold_reg.data;
    wire is_cmd = byte_arrived && hold_reg.first_in_frame;
    wire conv_wr = is_cmd && rx[CMD_CONV_BIT];
    wire setup_wr = is_cmd && !rx[CMD_CONV_BIT] && rx[CMD_SETUP_BIT];
    wire pass_on = byte_arrived && !conv_wr && !setup_wr;

    acd_conv_cfg_type conv_reg;
    acd_setup_cfg_type setup_reg;
    logic pol_wr_reg;
    logic [7:0] other_reg;
    logic other_first_reg;
    logic other_valid_reg;

    // Configuration fields update on whole command bytes only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            conv_reg <= '0;
            setup_reg <= '{CLK_MODE_RESET, REF_MODE_RESET, POL_SEL_RESET};
            pol_wr_reg <= 1'b0;
        end else begin
            if (conv_wr) begin
                conv_reg.channel <= rx[CONV_CH_MSB:CONV_CH_LSB];
                conv_reg.scan_mode <= rx[CONV_SCAN_MSB:CONV_SCAN_LSB];
                conv_reg.temp_req <= rx[CONV_TEMP_BIT];
            end
            if (setup_wr) begin
                setup_reg.clock_mode <= rx[SET_CLK_MSB:SET_CLK_LSB];
                setup_reg.reference_mode <= rx[SET_REF_MSB:SET_REF_LSB];
                setup_reg.polarity_select <= rx[SET_POL_MSB:SET_POL_LSB];
            end
            pol_wr_reg <= setup_wr;
        end
    end

    // Bytes not meant for this block go out untouched
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            other_reg <= 8'h00;
            other_first_reg <= 1'b0;
            other_valid_reg <= 1'b0;
        end else begin
            if (pass_on) begin
                other_reg <= rx;
                other_first_reg <= hold_reg.first_in_frame;
            end
            other_valid_reg <= pass_on;
        end
    end

    // ---- Mode decoding ----
    wire [1:0] cm = setup_reg.clock_mode;
    wire [1:0] rm = setup_reg.reference_mode;
    wire pin_is_start = (cm == CLK_INT_PIN_ACQ_INT) || (cm == CLK_INT_PIN_ACQ_PIN);
    wire second_reference_pin_is_input = !rm[0];
    wire serial_clocked = (cm == CLK_SERIAL);
    wire ref_forced = force_reference_on
        || ((rm == REF_INTERNAL) && (dac_any_powered || dac_any_parked));
    wire pin_fall = pin_d_reg && !pin_s2_reg;
    wire scan_start = pin_is_start ? pin_fall : conv_wr;
    logic [3:0] start_ch_pin;
    logic [3:0] second_reference_pin_ch_pin;
    assign start_ch_pin = 4'(NUM_CH - 1);
    assign second_reference_pin_ch_pin = 4'(NUM_CH - 2);

    // Conversion clock: internal divider, or the serial clock in mode 11
    logic [7:0] div_reg;
    wire div_wrap = (div_reg == 8'(INT_CLK_DIV - 1));
    wire sclk_rise = sclk_s2_reg && !sclk_d_reg;
    wire conv_tick = serial_clocked ? sclk_rise : div_wrap;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_wrap ? 8'h00 : div_reg + 8'h01;
        end
    end

    // A channel sitting on the start pin or second reference is not converted
    function automatic logic ch_skipped(input logic [3:0] ch, input logic pin_start,
                                        input logic second_reference_pin_in, input logic [3:0] sp,
                                        input logic [3:0] r2);
        ch_skipped = (pin_start && (ch == sp)) || (!second_reference_pin_in && (ch == r2));
    endfunction

    // ---- Scan sequencer ----
    acd_state_type state_reg, state_next;
    logic [3:0] cur_reg, cur_next;
    logic [3:0] last_reg, last_next;
    logic [4:0] rep_reg, rep_next;
    logic [4:0] reps_set_reg, reps_set_next;
    logic [7:0] wait_reg, wait_next;
    logic ref_on_reg, ref_on_next;
    logic temp_reg, temp_next;
    logic req_reg, req_next;

    wire [4:0] repeat_total = 5'((int'(repeat_count) + 1) * REPEAT_UNIT);
    wire skip_now = ch_skipped(cur_reg, pin_is_start, second_reference_pin_is_input,
                               start_ch_pin, second_reference_pin_ch_pin);
    wire need_ref = (rm == REF_INTERNAL) && !ref_on_reg && !ref_forced;
    // A conversion write that starts the scan brings its own fields, not the stale ones
    acd_conv_cfg_type scan_cfg;
    assign scan_cfg = conv_wr ? acd_conv_cfg_type'(rx[CONV_CH_MSB:CONV_TEMP_BIT]) : conv_reg;

    // Next-state logic of the scan
    always_comb begin
        state_next = state_reg;
        cur_next = cur_reg;
        last_next = last_reg;
        rep_next = rep_reg;
        reps_set_next = reps_set_reg;
        wait_next = wait_reg;
        ref_on_next = ref_on_reg;
        temp_next = temp_reg;
        req_next = req_reg;
        case (state_reg)
            ST_IDLE: begin
                if (scan_start) begin
                    case (scan_cfg.scan_mode)
                        SCAN_UP_TO_N: begin
                            cur_next = 4'h0;
                            last_next = scan_cfg.channel;
                            reps_set_next = 5'h01;
                        end
                        SCAN_N_TO_TOP: begin
                            cur_next = scan_cfg.channel;
                            last_next = 4'(NUM_CH - 1);
                            reps_set_next = 5'h01;
                        end
                        SCAN_REPEAT: begin
                            cur_next = scan_cfg.channel;
                            last_next = scan_cfg.channel;
                            reps_set_next = repeat_total;
                        end
                        default: begin
                            cur_next = scan_cfg.channel;
                            last_next = scan_cfg.channel;
                            reps_set_next = 5'h01;
                        end
                    endcase
                    rep_next = reps_set_next;
                    if (scan_cfg.temp_req) begin
                        ref_on_next = 1'b1;
                        wait_next = ref_forced ? DLY_TEMP_FORCED : DLY_TEMP_SETTLE;
                        state_next = ST_TEMP_WAIT;
                    end else if (need_ref) begin
                        ref_on_next = 1'b1;
                        wait_next = DLY_REF_WAKE;
                        state_next = ST_REF_WAIT;
                    end else begin
                        state_next = ST_CH_SEL;
                    end
                end
            end
            ST_TEMP_WAIT: begin
                if (conv_tick) begin
                    wait_next = wait_reg - 8'h01;
                    if (wait_reg == 8'h01) begin
                        temp_next = 1'b1;
                        req_next = 1'b1;
                        state_next = ST_TEMP_CONV;
                    end
                end
            end
            ST_TEMP_CONV: begin
                if (conv_done) begin
                    temp_next = 1'b0;
                    req_next = 1'b0;
                    state_next = ST_CH_SEL;
                end
            end
            ST_REF_WAIT: begin
                if (conv_tick) begin
                    wait_next = wait_reg - 8'h01;
                    if (wait_reg == 8'h01) begin
                        state_next = ST_CH_SEL;
                    end
                end
            end
            ST_CH_SEL: begin
                if (!skip_now) begin
                    req_next = 1'b1;
                    state_next = ST_CH_CONV;
                end else if (cur_reg >= last_reg) begin
                    ref_on_next = 1'b0;
                    state_next = ST_IDLE;
                end else begin
                    cur_next = cur_reg + 4'h1;
                    rep_next = reps_set_reg;
                end
            end
            ST_CH_CONV: begin
                if (conv_done) begin
                    req_next = 1'b0;
                    if (rep_reg > 5'h01) begin
                        rep_next = rep_reg - 5'h01;
                        state_next = ST_CH_SEL;
                    end else if (cur_reg >= last_reg) begin
                        ref_on_next = 1'b0;
                        state_next = ST_IDLE;
                    end else begin
                        cur_next = cur_reg + 4'h1;
                        rep_next = reps_set_reg;
                        state_next = ST_CH_SEL;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                req_next = 1'b0;
                temp_next = 1'b0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cur_reg <= 4'h0;
            last_reg <= 4'h0;
            rep_reg <= 5'h00;
            reps_set_reg <= 5'h00;
            wait_reg <= 8'h00;
            ref_on_reg <= 1'b0;
            temp_reg <= 1'b0;
            req_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            last_reg <= last_next;
            rep_reg <= rep_next;
            reps_set_reg <= reps_set_next;
            wait_reg <= wait_next;
            ref_on_reg <= ref_on_next;
            temp_reg <= temp_next;
            req_reg <= req_next;
        end
    end

    // Outputs
    assign conv_cfg = conv_reg;
    assign setup_cfg = setup_reg;
    assign pol_sel_wr = pol_wr_reg;
    assign other_cmd = other_reg;
    assign other_cmd_first = other_first_reg;
    assign other_cmd_valid = other_valid_reg;
    assign start_pin_is_input = !pin_is_start;
    assign second_ref_is_input = second_reference_pin_is_input;
    assign acq_by_start_pin = (cm == CLK_INT_PIN_ACQ_PIN) && !pin_s2_reg;
    assign conv_by_sclk = serial_clocked;
    assign ref_on = ref_on_reg || ref_forced;
    assign conv_req = req_reg;
    assign conv_channel = cur_reg;
    assign conv_temp = temp_reg;
    assign scan_busy = (state_reg != ST_IDLE);
endmodule

/* dv/acd_host_model.sv */
// Serial host model: frames command bytes onto the link and pulses the start pin
`timescale 1ns/10ps
module acd_host_model (
    output logic sclk_link,
    output logic cs_n,
    output logic sdi,
    output logic convert_start_pin
);
    // Idle levels: clock stands still outside frames
    initial begin
        sclk_link = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        convert_start_pin = 1'b1;
    end
    // Shifts nbits MSB first; data line shows the inverse once released
    task automatic frame(input logic [15:0] data, input int nbits);
        #3.3 cs_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            sdi = data[i];
            #7.5 sclk_link = 1'b1;
            #7.5 sclk_link = 1'b0;
        end
        #7.5 cs_n = 1'b1;
        sdi = ~sdi;
    endtask
    // Low pulse on the start pin
    task automatic start_pulse();
        convert_start_pin = 1'b0;
        #12 convert_start_pin = 1'b1;
    endtask
endmodule

/* dv/acd_command_decode_chk.sv */
// Port-level checker for the command decoder
`timescale 1ns/10ps
module acd_command_decode_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic force_reference_on,
    input wire logic dac_any_powered,
    input wire logic dac_any_parked,
    input wire logic conv_done,
    input acd_pkg::acd_setup_cfg_type setup_cfg,
    input wire logic pol_sel_wr,
    input wire logic other_cmd_valid,
    input wire logic start_pin_is_input,
    input wire logic second_ref_is_input,
    input wire logic acq_by_start_pin,
    input wire logic conv_by_sclk,
    input wire logic ref_on,
    input wire logic conv_req,
    input wire logic scan_busy
);
    import acd_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Pulses, pin roles and reference override
    a_pol_wr_pulse: assert property (pol_sel_wr |=> !pol_sel_wr)
        else $error("polarity write pulse too long");
    a_other_pulse: assert property (other_cmd_valid |=> !other_cmd_valid)
        else $error("pass-on pulse too long");
    a_start_pin_role: assert property (start_pin_is_input == setup_cfg.clock_mode[1])
        else $error("start pin role wrong");
    a_serial_clock: assert property (conv_by_sclk == (setup_cfg.clock_mode == CLK_SERIAL))
        else $error("serial clock select wrong");
    a_second_reference_pin_role: assert property (second_ref_is_input == !setup_cfg.reference_mode[0])
        else $error("second reference role wrong");
    a_acq_by_pin: assert property (acq_by_start_pin |-> setup_cfg.clock_mode == 2'h1)
        else $error("pin acquisition outside mode 01");
    a_force_ref: assert property (force_reference_on |-> ref_on)
        else $error("forced reference off");
    a_dac_ref: assert property ((setup_cfg.reference_mode == REF_INTERNAL)
        && (dac_any_powered || dac_any_parked) |-> ref_on)
        else $error("dac reference term off");
    // Request handshake
    a_req_hold: assert property (conv_req && !conv_done |=> conv_req)
        else $error("request dropped early");
    a_req_release: assert property (conv_req && conv_done |=> !conv_req)
        else $error("request not released");
    a_req_busy: assert property (conv_req |-> scan_busy)
        else $error("request while idle");
endmodule
bind acd_command_decode acd_command_decode_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .force_reference_on(force_reference_on), .dac_any_powered(dac_any_powered),
    .dac_any_parked(dac_any_parked), .conv_done(conv_done), .setup_cfg(setup_cfg),
    .pol_sel_wr(pol_sel_wr), .other_cmd_valid(other_cmd_valid),
    .start_pin_is_input(start_pin_is_input), .second_ref_is_input(second_ref_is_input),
    .acq_by_start_pin(acq_by_start_pin), .conv_by_sclk(conv_by_sclk), .ref_on(ref_on),
    .conv_req(conv_req), .scan_busy(scan_busy));

/* dv/acd_command_decode_test.sv */
// Self-checking bench for the command decoder
`timescale 1ns/10ps
module acd_command_decode_test;
    import acd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sclk_link, cs_n, sdi, convert_start_pin;
    logic force_reference_on = 1'b0;
    logic dac_any_powered = 1'b0;
    logic dac_any_parked = 1'b0;
    logic [1:0] repeat_count = 2'h1;
    logic conv_done = 1'b0;
    acd_conv_cfg_type conv_cfg;
    acd_setup_cfg_type setup_cfg;
    logic pol_sel_wr, other_cmd_first, other_cmd_valid, start_pin_is_input;
    logic second_ref_is_input, acq_by_start_pin, conv_by_sclk, ref_on;
    logic conv_req, conv_temp, scan_busy;
    logic [7:0] other_cmd;
    logic [3:0] conv_channel;
    int errors = 0;
    int cmp_count = 0;
    int rs = 0;
    int pol_cnt = 0;
    logic [4:0] got_q[$];
    logic [4:0] exp_q[$];
    logic [8:0] oth_q[$];

    always #2 clk_sys = ~clk_sys;

    acd_host_model u_acd_host_model (.sclk_link(sclk_link), .cs_n(cs_n), .sdi(sdi),
        .convert_start_pin(convert_start_pin));

    acd_command_decode #(.NUM_CH(12), .INT_CLK_DIV(1), .REPEAT_UNIT(2)) u_acd_command_decode (
        .clk_sys(clk_sys), .rst_n(rst_n), .sclk_link(sclk_link), .cs_n(cs_n), .sdi(sdi),
        .convert_start_pin(convert_start_pin), .force_reference_on(force_reference_on),
        .dac_any_powered(dac_any_powered), .dac_any_parked(dac_any_parked),
        .repeat_count(repeat_count), .conv_done(conv_done), .conv_cfg(conv_cfg),
        .setup_cfg(setup_cfg), .pol_sel_wr(pol_sel_wr), .other_cmd(other_cmd),
        .other_cmd_first(other_cmd_first), .other_cmd_valid(other_cmd_valid),
        .start_pin_is_input(start_pin_is_input), .second_ref_is_input(second_ref_is_input),
        .acq_by_start_pin(acq_by_start_pin), .conv_by_sclk(conv_by_sclk), .ref_on(ref_on),
        .conv_req(conv_req), .conv_channel(conv_channel), .conv_temp(conv_temp),
        .scan_busy(scan_busy));

    // Converter stand-in: logs each request and answers three cycles later
    always @(posedge clk_sys) begin
        conv_done <= (rs == 1);
        if (rs != 0) begin
            rs <= rs - 1;
        end else if (conv_req === 1'b1 && conv_done === 1'b0) begin
            got_q.push_back({conv_temp, conv_temp ? 4'h0 : conv_channel});
            rs <= 3;
        end
        if (pol_sel_wr === 1'b1) begin
            pol_cnt <= pol_cnt + 1;
        end
        if (other_cmd_valid === 1'b1) begin
            oth_q.push_back({other_cmd_first, other_cmd});
        end
    end

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // Setup byte and resulting configuration and pin roles
    task automatic wr_setup(input logic [1:0] cm, input logic [1:0] rm, input logic [1:0] pol);
        u_acd_host_model.frame({10'h1, cm, rm, pol}, 8);
        cycles(8);
        chk_val("setup_cfg", {10'h0, cm, rm, pol}, {10'h0, setup_cfg});
        chk_val("conv_by_sclk", {15'h0, cm == 2'h3}, {15'h0, conv_by_sclk});
        chk_val("start_pin_is_input", {15'h0, cm[1]}, {15'h0, start_pin_is_input});
        chk_val("second_ref_is_input", {15'h0, !rm[0]}, {15'h0, second_ref_is_input});
    endtask

    // Conversion byte, optional pin start, first-request delay and request order
    task automatic run_scan(input logic [7:0] cmd, input bit by_pin, input int lat);
        int n;
        got_q.delete();
        u_acd_host_model.frame({8'h0, cmd}, 8);
        if (by_pin) begin
            cycles(20);
            chk_val("no start on write", 16'h0, {15'h0, scan_busy});
            u_acd_host_model.start_pulse();
        end
        n = 0;
        while (conv_req !== 1'b1 && n < 600) begin
            cycles(1);
            n++;
        end
        chk_rng("first request delay", lat - 4, lat + 10, n);
        n = 0;
        while (scan_busy !== 1'b0 && n < 600) begin
            cycles(1);
            n++;
        end
        chk_rng("scan end", 0, 599, n);
        cycles(4);
        chk_val("conv_cfg", {9'h0, cmd[6:0]}, {9'h0, conv_cfg});
        chk_val("request count", exp_q.size(), got_q.size());
        foreach (exp_q[i]) chk_val("request", {11'h0, exp_q[i]}, {11'h0, got_q[i]});
        exp_q.delete();
        $display("test done: scan %h", cmd);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        errors++;
        summarize();
    end

    initial begin
        cycles(2);
        chk_val("reset setup", {10'h0, CLK_MODE_RESET, REF_MODE_RESET, POL_SEL_RESET},
            {10'h0, setup_cfg});
        rst_n <= 1'b1;
        cycles(2);
        for (int m = 0; m < 4; m++) wr_setup(m[1:0], 2'h2, m[1:0]);
        // Internal timing: the serial clock stands still between frames
        wr_setup(2'h2, 2'h2, 2'h0);
        $display("test done: setup modes");
        exp_q = '{5'h0, 5'h1, 5'h2, 5'h3};
        run_scan(8'h98, 1'b0, 0);
        exp_q = '{5'h9, 5'ha, 5'hb};
        run_scan(8'hca, 1'b0, 0);
        exp_q = '{5'h5, 5'h5, 5'h5, 5'h5};
        run_scan(8'hac, 1'b0, 0);
        exp_q = '{5'h10, 5'h7};
        run_scan(8'hbf, 1'b0, 244);
        force_reference_on <= 1'b1;
        exp_q = '{5'h10, 5'h0};
        run_scan(8'h87, 1'b0, 188);
        force_reference_on <= 1'b0;
        wr_setup(2'h2, 2'h0, 2'h1);
        exp_q = '{5'h2};
        run_scan(8'h96, 1'b0, 218);
        chk_val("ref released", 16'h0, {15'h0, ref_on});
        dac_any_parked <= 1'b1;
        cycles(2);
        chk_val("dac ref on", 16'h1, {15'h0, ref_on});
        dac_any_parked <= 1'b0;
        wr_setup(2'h0, 2'h1, 2'h3);
        exp_q = '{5'h9};
        run_scan(8'hca, 1'b1, 0);
        wr_setup(2'h3, 2'h3, 2'h2);
        exp_q = '{5'h4};
        run_scan(8'ha6, 1'b0, 0);
        u_acd_host_model.frame(16'h2a80, 16);
        u_acd_host_model.frame(16'h000b, 5);
        cycles(10);
        chk_val("pass-on count", 16'h2, oth_q.size());
        chk_val("first pass-on", 16'h12a, {7'h0, oth_q[0]});
        chk_val("second pass-on", 16'h080, {7'h0, oth_q[1]});
        chk_val("setup kept", 16'h3e, {10'h0, setup_cfg});
        chk_val("conv kept", 16'h26, {9'h0, conv_cfg});
        chk_val("setup pulses", 16'h8, pol_cnt[15:0]);
        $display("test done: pass-on and partial byte");
        summarize();
    end
endmodule
